/* core/bbet_pkg.sv */
// shared constants and helpers of the built-in bit error tester
package bbet_pkg;
  // pattern select codes
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_2047 = 2'h1;
  localparam logic [1:0] SEL_2E23 = 2'h2;
  // generator seed, any nonzero value
  localparam logic [22:0] GEN_SEED = 23'h7FFFFF;
  // one-second time base
  localparam int CLK_HZ = 20_000_000;
  localparam int SECOND_MS = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * SECOND_MS;
  // sync acquire and loss thresholds
  localparam int SYNC_RUN = 64;
  localparam int LOSS_WIN = 64;
  localparam int LOSS_ERR = 8;
  // result formats
  localparam logic [13:0] EFS_FULL = 14'h2710;
  localparam logic [2:0] BER_DIGITS = 3'h4;
  localparam logic [2:0] EFS_DIGITS = 3'h5;
  localparam logic [4:0] POW_MAX = 5'h14;

  // feedback bit of either sequence
  function automatic logic bbet_fb(input logic [22:0] s, input logic [1:0] sel);
    return (sel == SEL_2047) ? (s[10] ^ s[8]) : (s[22] ^ s[17]);
  endfunction

  // a direction runs only with a valid pattern
  function automatic logic bbet_sel_on(input logic [1:0] sel);
    return (sel == SEL_2047) || (sel == SEL_2E23);
  endfunction
endpackage

/* core/bbet_dec_div.sv */
// decimal long divider giving normalised digits and a power of ten
`timescale 1ns/1ps
`default_nettype none
module bbet_dec_div (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire logic scale_in,
  input wire logic [2:0] digits_in,
  input wire logic [39:0] num_in,
  input wire logic [39:0] den_in,
  output logic done_out,
  output logic [13:0] value_out,
  output logic [4:0] power_out
);
  typedef enum logic [2:0] {DV_IDLE = 3'h1, DV_SCALE = 3'h2, DV_DIGIT = 3'h4} bbet_dv_t;
  bbet_dv_t st_r, st_nxt;
  logic [47:0] rem_r, rem_nxt;
  logic [39:0] den_r, den_nxt;
  logic [13:0] val_r, val_nxt;
  logic [4:0] pow_r, pow_nxt;
  logic [2:0] cnt_r, cnt_nxt, dig_r, dig_nxt;
  logic done_r, done_nxt;

  function automatic logic [47:0] mul10(input logic [47:0] r);
    return 48'(r * 10);
  endfunction

  // scale until quotient is at least one or power reaches POW_MAX, then one subtraction or digit shift per cycle
  always_comb begin
    st_nxt = st_r;
    rem_nxt = rem_r;
    den_nxt = den_r;
    val_nxt = val_r;
    pow_nxt = pow_r;
    cnt_nxt = cnt_r;
    dig_nxt = dig_r;
    done_nxt = 1'b0;
    case (st_r)
      DV_IDLE: begin
        if (start_in) begin
          rem_nxt = {8'h00, num_in};
          den_nxt = den_in;
          val_nxt = 14'h0000;
          pow_nxt = 5'h00;
          cnt_nxt = 3'h1;
          dig_nxt = digits_in;
          st_nxt = scale_in ? DV_SCALE : DV_DIGIT;
        end
      end
      DV_SCALE: begin
        if (rem_r == 48'h0 || den_r == 40'h0) begin
          done_nxt = 1'b1;
          st_nxt = DV_IDLE;
        end else if (rem_r < {8'h00, den_r} && pow_r != bbet_pkg::POW_MAX) begin
          rem_nxt = mul10(rem_r);
          pow_nxt = pow_r + 5'h01;
        end else begin
          st_nxt = DV_DIGIT;
        end
      end
      DV_DIGIT: begin
        if (den_r == 40'h0) begin
          done_nxt = 1'b1;
          st_nxt = DV_IDLE;
        end else if (rem_r >= {8'h00, den_r}) begin
          rem_nxt = rem_r - {8'h00, den_r};
          val_nxt = val_r + 14'h0001;
        end else if (cnt_r == dig_r) begin
          done_nxt = 1'b1;
          st_nxt = DV_IDLE;
        end else begin
          val_nxt = 14'(val_r * 10);
          rem_nxt = mul10(rem_r);
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      default: st_nxt = DV_IDLE;
    endcase
  end

  // divider registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r <= DV_IDLE;
      rem_r <= 48'h0;
      den_r <= 40'h0;
      val_r <= 14'h0000;
      pow_r <= 5'h00;
      cnt_r <= 3'h0;
      dig_r <= 3'h0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      rem_r <= rem_nxt;
      den_r <= den_nxt;
      val_r <= val_nxt;
      pow_r <= pow_nxt;
      cnt_r <= cnt_nxt;
      dig_r <= dig_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_out = done_r;
  assign value_out = val_r;
  assign power_out = pow_r;
endmodule
`default_nettype wire

/* core/bbet_top.sv */
// built-in bit error tester: generator, checker, statistics
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE_01 - each direction runs only with the 2047 or 2^23-1 pattern selected
// RULE_02 - controller selects the same pattern for both directions
// RULE_03 - generator and checker are fully independent
// RULE_04 - error ratio given as mantissa below ten and power of ten
// RULE_05 - count every loss of pattern sync since restart
// RULE_06 - count bit errors, never while sync is lost
// RULE_07 - count every received bit since restart
// RULE_08 - error-free second percentage, clean run reads 100.00
// RULE_09 - count errored seconds, seconds out of sync count errored
// RULE_10 - count total whole seconds since restart
// RULE_11 - one restart clears every counter and result together
// RULE_12 - insert command inverts exactly one transmitted bit
// RULE_13 - data on either loop-back path bypasses the tester
// RULE_14 - controller keeps satellite loop-back off while testing
// RULE_15 - generator feeds modulator side, checker reads demodulator side only
// RULE_16 - all settings and results reachable as plain ports
// RULE_17 - sync after a clean run, loss on error density in a window
// RULE_18 - one-second tick from the system clock bounds each second
module bbet_top #(
  parameter int TICK_CYCLES = bbet_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [1:0] tx_pattern_select_in,
  input wire logic [1:0] rx_pattern_select_in,
  input wire logic insert_error_in,
  input wire logic restart_in,
  input wire logic loop_ter_in,
  input wire logic loop_sat_in,
  input wire logic tx_bit_en_in,
  input wire logic term_tx_data_in,
  input wire logic rx_bit_en_in,
  input wire logic rx_data_in,
  output logic mod_data_out,
  output logic term_rx_data_out,
  output logic tx_active_out,
  output logic rx_active_out,
  output logic rx_sync_out,
  output logic [13:0] measured_error_ratio_out,
  output logic [4:0] ratio_power_out,
  output logic [15:0] sync_loss_count_out,
  output logic [31:0] error_count_out,
  output logic [39:0] bit_count_out,
  output logic [13:0] error_free_second_percent_out,
  output logic [31:0] errored_sec_out,
  output logic [31:0] total_sec_out
);
  typedef enum logic [1:0] {CK_HUNT = 2'h1, CK_LOCK = 2'h2} bbet_ck_t;
  typedef enum logic [2:0] {RS_IDLE = 3'h1, RS_BER = 3'h2, RS_EFS = 3'h4} bbet_rs_t;

  logic tx_on, rx_on, rx_stb, gen_bit, pred, bit_err, clr, sel_chg, tick, ev;
  logic [22:0] gen_r, gen_nxt, chk_r, chk_nxt;
  logic pend_r, pend_nxt, mod_r, mod_nxt, trx_r, trx_nxt;
  bbet_ck_t ck_r, ck_nxt;
  logic [6:0] run_r, run_nxt, win_r, win_nxt;
  logic [3:0] werr_r, werr_nxt;
  logic [24:0] tcnt_r, tcnt_nxt;
  logic [1:0] rsel_r;
  logic sec_err_r, sec_err_nxt;
  logic [15:0] loss_r, loss_nxt;
  logic [31:0] errs_r, errs_nxt, esec_r, esec_nxt, fsec_r, fsec_nxt, tsec_r, tsec_nxt;
  logic [39:0] bits_r, bits_nxt;
  bbet_rs_t ph_r, ph_nxt;
  logic [13:0] ber_r, ber_nxt, efs_r, efs_nxt, dv_val;
  logic [4:0] pow_r, pow_nxt, dv_pow;
  logic dv_start, dv_done, dv_efs;

  // RULE_01 RULE_03 RULE_13 independent direction enables
  assign tx_on = bbet_pkg::bbet_sel_on(tx_pattern_select_in) & ~loop_sat_in;
  assign rx_on = bbet_pkg::bbet_sel_on(rx_pattern_select_in) & ~loop_sat_in;
  assign rx_stb = rx_on & rx_bit_en_in;
  assign gen_bit = bbet_pkg::bbet_fb(gen_r, tx_pattern_select_in);
  assign pred = bbet_pkg::bbet_fb(chk_r, rx_pattern_select_in);
  assign bit_err = rx_data_in ^ pred;
  // RULE_11 restart on request or on a new receive pattern
  assign sel_chg = (rx_pattern_select_in != rsel_r);
  assign clr = restart_in | sel_chg;
  // RULE_18 one-second tick
  assign tick = rx_on & (tcnt_r == 25'(TICK_CYCLES - 1));
  // RULE_09 second is spoiled by a counted error or by lost sync
  assign ev = (rx_stb & (ck_r == CK_LOCK) & bit_err) | (rx_on & (ck_r != CK_LOCK));

  // generator, error insertion and data path muxes
  always_comb begin
    gen_nxt = gen_r;
    mod_nxt = mod_r;
    trx_nxt = trx_r;
    // RULE_12 arm one inversion, set wins
    pend_nxt = (insert_error_in & tx_on) | (pend_r & ~(tx_on & tx_bit_en_in));
    if (loop_sat_in) begin
      // RULE_13 satellite loop-back returns demod data
      if (rx_bit_en_in) begin
        mod_nxt = rx_data_in;
      end
    end else if (tx_on & tx_bit_en_in) begin
      // RULE_15 pattern always toward modulator
      gen_nxt = {gen_r[21:0], gen_bit};
      mod_nxt = gen_bit ^ pend_r;
    end else if (tx_bit_en_in & ~tx_on) begin
      mod_nxt = term_tx_data_in;
    end
    // RULE_13 terrestrial loop-back bypasses checker
    if (loop_ter_in) begin
      if (tx_bit_en_in) begin
        trx_nxt = term_tx_data_in;
      end
    end else if (rx_bit_en_in) begin
      trx_nxt = rx_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      gen_r <= bbet_pkg::GEN_SEED;
      pend_r <= 1'b0;
      mod_r <= 1'b0;
      trx_r <= 1'b0;
    end else begin
      gen_r <= gen_nxt;
      pend_r <= pend_nxt;
      mod_r <= mod_nxt;
      trx_r <= trx_nxt;
    end
  end

  // checker, sync tracking and statistics
  always_comb begin
    chk_nxt = chk_r;
    ck_nxt = ck_r;
    run_nxt = run_r;
    win_nxt = win_r;
    werr_nxt = werr_r;
    tcnt_nxt = tcnt_r;
    sec_err_nxt = sec_err_r | ev;
    loss_nxt = loss_r;
    errs_nxt = errs_r;
    bits_nxt = bits_r;
    esec_nxt = esec_r;
    fsec_nxt = fsec_r;
    tsec_nxt = tsec_r;
    if (rx_on) begin
      tcnt_nxt = tick ? 25'h0 : tcnt_r + 25'h1;
    end
    if (rx_stb) begin
      // RULE_07 every received bit
      bits_nxt = bits_r + 40'h1;
      case (ck_r)
        CK_HUNT: begin
          // RULE_17 load received bits, wait for a clean run
          chk_nxt = {chk_r[21:0], rx_data_in};
          run_nxt = bit_err ? 7'h00 : run_r + 7'h01;
          if (~bit_err && run_r == 7'(bbet_pkg::SYNC_RUN - 1)) begin
            ck_nxt = CK_LOCK;
            win_nxt = 7'h00;
            werr_nxt = 4'h0;
          end
        end
        CK_LOCK: begin
          chk_nxt = {chk_r[21:0], pred};
          // RULE_06 errors counted in sync only
          if (bit_err) begin
            errs_nxt = errs_r + 32'h1;
          end
          // RULE_17 error density check over a window
          if (bit_err && werr_r == 4'(bbet_pkg::LOSS_ERR - 1)) begin
            // RULE_05 one more sync loss
            ck_nxt = CK_HUNT;
            loss_nxt = loss_r + 16'h1;
            run_nxt = 7'h00;
          end else if (win_r == 7'(bbet_pkg::LOSS_WIN - 1)) begin
            win_nxt = 7'h00;
            werr_nxt = 4'h0;
          end else begin
            win_nxt = win_r + 7'h01;
            werr_nxt = werr_r + {3'h0, bit_err};
          end
        end
        default: ck_nxt = CK_HUNT;
      endcase
    end
    if (tick) begin
      // RULE_10 RULE_09 close the second
      tsec_nxt = tsec_r + 32'h1;
      sec_err_nxt = 1'b0;
      if (sec_err_r | ev) begin
        esec_nxt = esec_r + 32'h1;
      end else begin
        fsec_nxt = fsec_r + 32'h1;
      end
    end
    // RULE_11 clear the time base and all statistics together
    if (clr) begin
      // new pattern must be hunted again, a plain restart keeps lock
      if (sel_chg) begin
        ck_nxt = CK_HUNT;
        run_nxt = 7'h00;
        win_nxt = 7'h00;
        werr_nxt = 4'h0;
      end
      tcnt_nxt = 25'h0;
      sec_err_nxt = 1'b0;
      loss_nxt = 16'h0;
      errs_nxt = 32'h0;
      bits_nxt = 40'h0;
      esec_nxt = 32'h0;
      fsec_nxt = 32'h0;
      tsec_nxt = 32'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chk_r <= 23'h0;
      ck_r <= CK_HUNT;
      run_r <= 7'h00;
      win_r <= 7'h00;
      werr_r <= 4'h0;
      tcnt_r <= 25'h0;
      rsel_r <= bbet_pkg::SEL_OFF;
      sec_err_r <= 1'b0;
      loss_r <= 16'h0;
      errs_r <= 32'h0;
      bits_r <= 40'h0;
      esec_r <= 32'h0;
      fsec_r <= 32'h0;
      tsec_r <= 32'h0;
    end else begin
      chk_r <= chk_nxt;
      ck_r <= ck_nxt;
      run_r <= run_nxt;
      win_r <= win_nxt;
      werr_r <= werr_nxt;
      tcnt_r <= tcnt_nxt;
      rsel_r <= rx_pattern_select_in;
      sec_err_r <= sec_err_nxt;
      loss_r <= loss_nxt;
      errs_r <= errs_nxt;
      bits_r <= bits_nxt;
      esec_r <= esec_nxt;
      fsec_r <= fsec_nxt;
      tsec_r <= tsec_nxt;
    end
  end

  // RULE_04 RULE_08 derived results, ratio then percentage
  assign dv_efs = (ph_r == RS_BER);
  assign dv_start = (tick & ~clr & (ph_r == RS_IDLE)) | (dv_done & dv_efs);

  bbet_dec_div u_div (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .start_in(dv_start),
    .scale_in(~dv_efs),
    .digits_in(dv_efs ? bbet_pkg::EFS_DIGITS : bbet_pkg::BER_DIGITS),
    .num_in(dv_efs ? {8'h00, fsec_r} : {8'h00, errs_r}),
    .den_in(dv_efs ? {8'h00, tsec_nxt} : bits_r),
    .done_out(dv_done),
    .value_out(dv_val),
    .power_out(dv_pow)
  );

  always_comb begin
    ph_nxt = ph_r;
    ber_nxt = ber_r;
    pow_nxt = pow_r;
    efs_nxt = efs_r;
    case (ph_r)
      RS_IDLE: begin
        if (dv_start) begin
          ph_nxt = RS_BER;
        end
      end
      RS_BER: begin
        if (dv_done) begin
          ber_nxt = dv_val;
          pow_nxt = dv_pow;
          ph_nxt = RS_EFS;
        end
      end
      RS_EFS: begin
        if (dv_done) begin
          efs_nxt = dv_val;
          ph_nxt = RS_IDLE;
        end
      end
      default: ph_nxt = RS_IDLE;
    endcase
    if (clr) begin
      ph_nxt = RS_IDLE;
      ber_nxt = 14'h0000;
      pow_nxt = 5'h00;
      efs_nxt = bbet_pkg::EFS_FULL;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ph_r <= RS_IDLE;
      ber_r <= 14'h0000;
      pow_r <= 5'h00;
      efs_r <= bbet_pkg::EFS_FULL;
    end else begin
      ph_r <= ph_nxt;
      ber_r <= ber_nxt;
      pow_r <= pow_nxt;
      efs_r <= efs_nxt;
    end
  end

  // RULE_16 every setting and result on plain ports
  assign mod_data_out = mod_r;
  assign term_rx_data_out = trx_r;
  assign tx_active_out = tx_on;
  assign rx_active_out = rx_on;
  assign rx_sync_out = (ck_r == CK_LOCK);
  assign measured_error_ratio_out = ber_r;
  assign ratio_power_out = pow_r;
  assign sync_loss_count_out = loss_r;
  assign error_count_out = errs_r;
  assign bit_count_out = bits_r;
  assign error_free_second_percent_out = efs_r;
  assign errored_sec_out = esec_r;
  assign total_sec_out = tsec_r;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_armed;
    pend_r & tx_on & tx_bit_en_in & ~loop_sat_in & ~insert_error_in;
  endsequence
  sequence s_step;
    tx_on & tx_bit_en_in & ~pend_r & ~insert_error_in;
  endsequence
  property p_tx_bypass;
    tx_bit_en_in & ~tx_on & ~loop_sat_in |=> mod_data_out == $past(term_tx_data_in);
  endproperty
  a_tx_bypass: assert property (p_tx_bypass) else $error("idle tx not bypassed"); // RULE_01
  property p_insert;
    s_armed |=> (mod_data_out != $past(gen_bit)) && !pend_r;
  endproperty
  a_insert: assert property (p_insert) else $error("error insertion wrong"); // RULE_12
  property p_clean;
    s_step |=> mod_data_out == $past(gen_bit);
  endproperty
  a_clean: assert property (p_clean) else $error("pattern bit corrupted"); // RULE_15
  property p_restart;
    restart_in |=> bits_r == 40'h0 && errs_r == 32'h0 && loss_r == 16'h0 && tsec_r == 32'h0
      && efs_r == bbet_pkg::EFS_FULL && ber_r == 14'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("restart left state"); // RULE_11
  property p_hunt_no_err;
    ~rx_sync_out & ~clr |=> $stable(errs_r);
  endproperty
  a_hunt_no_err: assert property (p_hunt_no_err) else $error("error counted out of sync"); // RULE_06
  property p_bits;
    rx_stb & ~clr |=> bits_r == $past(bits_r) + 40'h1;
  endproperty
  a_bits: assert property (p_bits) else $error("bit count missed"); // RULE_07
  property p_loss;
    rx_sync_out & ~clr ##1 ~rx_sync_out |-> loss_r == $past(loss_r) + 16'h1;
  endproperty
  a_loss: assert property (p_loss) else $error("sync loss not counted"); // RULE_05
  property p_secs;
    tick & ~clr |=> tsec_r == $past(tsec_r) + 32'h1 && esec_r + fsec_r == tsec_r;
  endproperty
  a_secs: assert property (p_secs) else $error("second counters off"); // RULE_10
  property p_hunt_sec;
    tick & ~clr & ~rx_sync_out |=> esec_r == $past(esec_r) + 32'h1;
  endproperty
  a_hunt_sec: assert property (p_hunt_sec) else $error("out of sync second clean"); // RULE_09
  property p_ranges;
    ber_r <= 14'h270F && efs_r <= bbet_pkg::EFS_FULL;
  endproperty
  a_ranges: assert property (p_ranges) else $error("result out of range"); // RULE_04
  property p_full;
    dv_done & (ph_r == RS_EFS) & (esec_r == 32'h0) & ~clr |=> efs_r == bbet_pkg::EFS_FULL;
  endproperty
  a_full: assert property (p_full) else $error("clean run not 100.00"); // RULE_08
  property p_lock;
    ~rx_sync_out ##1 rx_sync_out |-> $past(run_r) == 7'(bbet_pkg::SYNC_RUN - 1);
  endproperty
  a_lock: assert property (p_lock) else $error("lock without clean run"); // RULE_17
endmodule
`default_nettype wire

/* test/bbet_path_model.sv */
// modulator and demodulator data path model with bit strobes
`timescale 1ns/1ps
`default_nettype none
module bbet_path_model (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [1:0] mode_in,
  input wire logic mod_data_in,
  output logic tx_bit_en_out,
  output logic rx_bit_en_out,
  output logic rx_data_out
);
  logic [1:0] ph_r = 2'h0;
  // strobes every fourth cycle, rx two cycles after tx
  // satellite side sourced and read
  always @(posedge clk_in) begin
    if (srst_in) begin
      ph_r <= 2'h0;
      tx_bit_en_out <= 1'b0;
      rx_bit_en_out <= 1'b0;
      rx_data_out <= 1'b0;
    end else begin
      ph_r <= ph_r + 2'h1;
      tx_bit_en_out <= (ph_r == 2'h3);
      rx_bit_en_out <= (ph_r == 2'h1);
      // mode 0 clean loop, 1 every bit corrupted, 2 and 3 fixed levels
      if (ph_r == 2'h1) begin
        case (mode_in)
          2'h0: rx_data_out <= mod_data_in;
          2'h1: rx_data_out <= ~mod_data_in;
          2'h2: rx_data_out <= 1'b1;
          default: rx_data_out <= 1'b0;
        endcase
      end else begin
        rx_data_out <= ~rx_data_out; // not valid outside the strobe
      end
    end
  end
endmodule
`default_nettype wire

/* test/test_bbet_top.sv */
// self-checking bench of the built-in bit error tester
`timescale 1ns/1ps
`default_nettype none
module test_bbet_top;
  localparam int TICKS = 200;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [1:0] tx_sel = 2'h0;
  logic [1:0] rx_sel = 2'h0;
  logic insert = 1'b0;
  logic restart = 1'b0;
  logic loop_ter = 1'b0;
  logic loop_sat = 1'b0;
  logic term_tx = 1'b1;
  logic [1:0] mode = 2'h0;
  logic tx_en, rx_en, rx_data, mod_data, term_rx, tx_act, rx_act, rx_sync;
  logic [13:0] ratio, error_free_second_percent;
  logic [4:0] power;
  logic [15:0] losses;
  logic [31:0] errs, err_sec, tot_sec;
  logic [39:0] bits;
  int miscompares = 0;
  int check_count = 0;
  int rx_cnt = 0;
  logic tx_q = 1'b0;
  logic hist[$];

  always #25 clk_in = ~clk_in;

  // transmitted bit history and received bit tally
  always @(posedge clk_in) begin
    tx_q <= tx_en;
    if (tx_q === 1'b1) hist.push_back(mod_data);
    if (restart) rx_cnt <= 0;
    else if (rx_en && rx_act) rx_cnt <= rx_cnt + 1;
  end

  bbet_top #(.TICK_CYCLES(TICKS)) u_bbet_top (.clk_in(clk_in), .srst_in(srst_in),
    .tx_pattern_select_in(tx_sel), .rx_pattern_select_in(rx_sel),
    .insert_error_in(insert), .restart_in(restart), .loop_ter_in(loop_ter),
    .loop_sat_in(loop_sat), .tx_bit_en_in(tx_en), .term_tx_data_in(term_tx),
    .rx_bit_en_in(rx_en), .rx_data_in(rx_data), .mod_data_out(mod_data),
    .term_rx_data_out(term_rx), .tx_active_out(tx_act), .rx_active_out(rx_act),
    .rx_sync_out(rx_sync), .measured_error_ratio_out(ratio), .ratio_power_out(power),
    .sync_loss_count_out(losses), .error_count_out(errs), .bit_count_out(bits),
    .error_free_second_percent_out(error_free_second_percent), .errored_sec_out(err_sec),
    .total_sec_out(tot_sec));

  bbet_path_model u_bbet_path_model (.clk_in(clk_in), .srst_in(srst_in), .mode_in(mode),
    .mod_data_in(mod_data), .tx_bit_en_out(tx_en), .rx_bit_en_out(rx_en),
    .rx_data_out(rx_data));

  // compare and tally
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wait_tx(input int n);
    repeat (n) @(posedge clk_in iff tx_en === 1'b1);
  endtask

  task automatic wait_sync(input logic v);
    for (int i = 0; i < 2000 && rx_sync !== v; i++) @(posedge clk_in);
    check(rx_sync, v);
  endtask

  task automatic pulse_insert;
    @(posedge clk_in) insert <= 1'b1;
    @(posedge clk_in) insert <= 1'b0;
  endtask

  // recurrence violations over the captured bits
  function automatic int viol(input int a, input int b);
    int n = 0;
    for (int k = a; k < hist.size(); k++) if (hist[k] !== (hist[k-a] ^ hist[k-b])) n++;
    return n;
  endfunction

  task automatic t_enable;
    check(error_free_second_percent, bbet_pkg::EFS_FULL);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_in);
      tx_sel <= s[1:0];
      rx_sel <= s[1:0];
      repeat (2) @(posedge clk_in);
      check(tx_act, s == 1 || s == 2);
      check(rx_act, s == 1 || s == 2);
    end
    $display("enable test done");
  endtask

  task automatic t_gen;
    @(posedge clk_in) rx_sel <= bbet_pkg::SEL_OFF;
    for (int s = 1; s < 3; s++) begin
      @(posedge clk_in) tx_sel <= s[1:0];
      wait_tx(30);
      hist.delete();
      wait_tx(30);
      pulse_insert();
      wait_tx(60);
      check(rx_act, 1'b0);
      check(viol(s == 1 ? 11 : 23, s == 1 ? 9 : 18), 3);
    end
    $display("generator test done");
  endtask

  task automatic t_lock;
    @(posedge clk_in iff rx_en === 1'b1);
    tx_sel <= bbet_pkg::SEL_2047;
    rx_sel <= bbet_pkg::SEL_2047;
    restart <= 1'b1;
    @(posedge clk_in) restart <= 1'b0;
    repeat (6 * TICKS + 150) @(posedge clk_in);
    @(negedge clk_in);
    check(rx_sync, 1'b1);
    check(tot_sec, 6);
    check(err_sec, 2);
    check(errs, 0);
    check(ratio, 0);
    check(bits, rx_cnt);
    check(error_free_second_percent == 14'd6666 || error_free_second_percent == 14'd6667, 1);
    pulse_insert();
    repeat (2 * TICKS) @(posedge clk_in);
    @(negedge clk_in);
    check(errs, 1);
    check(err_sec, 3);
    check(tot_sec, 8);
    check(power, 3);
    check(ratio >= 14'd2400 && ratio <= 14'd2600, 1);
    $display("lock test done");
  endtask

  task automatic t_loss;
    logic [31:0] e0;
    logic [31:0] s0;
    logic [31:0] e1;
    s0 = err_sec;
    e1 = errs;
    @(posedge clk_in) mode <= 2'h1;
    wait_sync(1'b0);
    @(negedge clk_in);
    e0 = errs;
    check(losses, 1);
    check(e0 - e1 >= 32'(bbet_pkg::LOSS_ERR), 1);
    check(e0 - e1 <= 32'(2 * bbet_pkg::LOSS_ERR - 1), 1);
    repeat (3 * TICKS) @(posedge clk_in);
    @(negedge clk_in);
    check(errs, e0);
    check(err_sec - s0 >= 32'd3, 1);
    @(posedge clk_in) mode <= 2'h0;
    wait_sync(1'b1);
    $display("sync loss test done");
  endtask

  task automatic t_restart;
    @(posedge clk_in iff rx_en === 1'b1) restart <= 1'b1;
    @(posedge clk_in) restart <= 1'b0;
    @(negedge clk_in);
    check(bits, 0);
    check(errs, 0);
    check(losses, 0);
    check(err_sec, 0);
    check(tot_sec, 0);
    check({error_free_second_percent, ratio}, {bbet_pkg::EFS_FULL, 14'h0});
    // clean link after restart keeps every second error free
    repeat (2 * TICKS + 100) @(posedge clk_in);
    @(negedge clk_in);
    check(tot_sec, 2);
    check(err_sec, 0);
    check(error_free_second_percent, bbet_pkg::EFS_FULL);
    check(ratio, 0);
    $display("restart test done");
  endtask

  task automatic t_loop;
    logic [39:0] b;
    @(posedge clk_in);
    loop_sat <= 1'b1;
    mode <= 2'h2;
    wait_tx(3);
    @(negedge clk_in);
    check({tx_act, rx_act, mod_data}, 3'h1);
    b = bits;
    @(posedge clk_in) mode <= 2'h3;
    wait_tx(3);
    @(negedge clk_in);
    check(bits, b);
    check(mod_data, 1'b0);
    @(posedge clk_in);
    loop_sat <= 1'b0;
    loop_ter <= 1'b1;
    term_tx <= 1'b0;
    wait_tx(2);
    @(negedge clk_in);
    check(term_rx, 1'b0);
    @(posedge clk_in) term_tx <= 1'b1;
    wait_tx(2);
    @(negedge clk_in);
    check(term_rx, 1'b1);
    $display("loop-back test done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk_in);
    miscompares++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    t_enable();
    t_gen();
    t_lock();
    t_loss();
    t_restart();
    t_loop();
    summarize();
  end
endmodule
`default_nettype wire
